//--- hdl/pec_regs.svh
`ifndef PEC_REGS_SVH
`define PEC_REGS_SVH

`define PEC_DAL_W       18
`define PEC_CSR_W       16
`define PEC_JMP_W       4
`define PEC_CSR_EN      0
`define PEC_CSR_WWP     2
`define PEC_CSR_EA_LO   5
`define PEC_CSR_EA_HI   11
`define PEC_CSR_FLAG    15
`define PEC_EA_W        7
`define PEC_ADR_EA_LO   11
`define PEC_ADR_EA_HI   17
`define PEC_ADR_BASE_LO 5
`define PEC_ADR_BASE_HI 17
`define PEC_ADR_JMP_LO  1
`define PEC_ADR_JMP_HI  4
`define PEC_ADR_BASE    13'h1FA2
`define PEC_DAL_PERR    16
`define PEC_DAL_PEN     17
`define PEC_CSR_RESET   16'h0000

`endif

//--- hdl/pec_pkg.sv
`default_nettype none
package pec_pkg;

  // Bus lines as asserted levels
  typedef struct packed {
    logic        sync;
    logic        din;
    logic        dout;
    logic        rply;
    logic        wtbt;
    logic        init;
    logic [17:0] dal;
  } pec_bus_t;

  // Lines this block drives
  typedef struct packed {
    logic [17:0] dal;
    logic [17:0] dal_oe;
    logic        rply;
  } pec_drv_t;

  typedef enum logic [4:0] {
    PEC_IDLE = 5'h01,
    PEC_CYC  = 5'h02,
    PEC_RD   = 5'h04,
    PEC_WR   = 5'h08,
    PEC_WAIT = 5'h10
  } pec_state_t;

endpackage : pec_pkg
`default_nettype wire

//--- hdl/pec_sync.sv
`default_nettype none
module pec_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pec_sync_st_t;

  pec_sync_st_t s;
  pec_sync_st_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;

endmodule : pec_sync
`default_nettype wire

//--- hdl/pec_top.sv
`include "pec_regs.svh"
`default_nettype none
module pec_top
  import pec_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  input  wire pec_bus_t               bus_i,
  input  wire logic [`PEC_JMP_W-1:0]  jumper_i,
  output logic      [`PEC_DAL_W-1:0]  dal_o,
  output logic      [`PEC_DAL_W-1:0]  dal_oe_o,
  output logic                        rply_o
);

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    pec_state_t              st;
    logic                    sync_d;
    logic                    rply_d;
    logic                    sel;
    logic                    adr0;
    logic                    en;
    logic                    wwp;
    logic                    flag;
    logic [`PEC_EA_W-1:0]    err_adr;
    pec_drv_t                drv;
  } pec_top_st_t;

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SW = $bits(pec_bus_t) + `PEC_JMP_W;

  logic [SW-1:0]        sync_q;
  pec_bus_t             b;
  logic [`PEC_JMP_W-1:0] jmp;

  pec_sync #(
    .W (SW)
  ) u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({bus_i, jumper_i}),
    .q_o       (sync_q)
  );

  assign b   = sync_q[SW-1:`PEC_JMP_W];
  assign jmp = sync_q[`PEC_JMP_W-1:0];

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic csr_hit(
    input logic [`PEC_DAL_W-1:0] a,
    input logic [`PEC_JMP_W-1:0] j
  );
    logic base_ok;
    logic jmp_ok;
    base_ok = (a[`PEC_ADR_BASE_HI:`PEC_ADR_BASE_LO] == `PEC_ADR_BASE);
    jmp_ok  = (a[`PEC_ADR_JMP_HI:`PEC_ADR_JMP_LO] == j);
    return base_ok & jmp_ok;
  endfunction : csr_hit

  function automatic logic [`PEC_CSR_W-1:0] csr_word(
    input logic                 en,
    input logic                 wwp,
    input logic                 flag,
    input logic [`PEC_EA_W-1:0] ea
  );
    logic [`PEC_CSR_W-1:0] w;
    w = `PEC_CSR_RESET;
    w[`PEC_CSR_EN] = en;
    w[`PEC_CSR_WWP] = wwp;
    w[`PEC_CSR_EA_HI:`PEC_CSR_EA_LO] = ea;
    w[`PEC_CSR_FLAG] = flag;
    return w;
  endfunction : csr_word

  // ****************************************
  // State
  // ****************************************
  pec_top_st_t s;
  pec_top_st_t next_s;

  logic sync_rise;
  logic rply_rise;
  logic flag_set;
  logic flag_clr;
  logic wr_low;

  always_comb begin
    next_s    = s;
    sync_rise = b.sync & ~s.sync_d;
    rply_rise = b.rply & ~s.rply_d;
    flag_clr  = 1'b0;
    wr_low    = 1'b0;

    next_s.sync_d = b.sync;
    next_s.rply_d = b.rply;

    // Parity error seen by a foreign read
    flag_set = b.din & rply_rise & b.dal[`PEC_DAL_PERR] & ~s.sel;

    // Drivers default to released
    next_s.drv.dal    = '0;
    next_s.drv.dal_oe = '0;
    next_s.drv.rply   = 1'b0;

    // Parity enable on line 17
    if (s.en && b.din) begin
      next_s.drv.dal[`PEC_DAL_PEN]    = 1'b1;
      next_s.drv.dal_oe[`PEC_DAL_PEN] = 1'b1;
    end

    // Force wrong parity on foreign writes
    if (s.wwp && b.dout && !s.sel) begin
      next_s.drv.dal[`PEC_DAL_PERR]    = 1'b1;
      next_s.drv.dal_oe[`PEC_DAL_PERR] = 1'b1;
    end

    // ****************************************
    // Bus cycle sequencer
    // ****************************************
    case (s.st)
      PEC_IDLE: begin
        if (sync_rise) begin
          next_s.sel  = csr_hit(b.dal, jmp);
          next_s.adr0 = b.dal[0];
          if (!(s.flag || flag_set)) begin
            next_s.err_adr = b.dal[`PEC_ADR_EA_HI:`PEC_ADR_EA_LO];
          end
          next_s.st = PEC_CYC;
        end
      end
      PEC_CYC: begin
        if (!b.sync) begin
          next_s.sel = 1'b0;
          next_s.st  = PEC_IDLE;
        end else if (s.sel && b.din) begin
          next_s.st = PEC_RD;
        end else if (s.sel && b.dout) begin
          wr_low    = ~(b.wtbt & s.adr0);
          next_s.st = PEC_WR;
        end
      end
      PEC_RD: begin
        next_s.drv.dal[`PEC_CSR_W-1:0] =
          csr_word(s.en, s.wwp, s.flag, s.err_adr);
        next_s.drv.dal_oe[`PEC_CSR_W-1:0] = '1;
        next_s.drv.rply = 1'b1;
        if (!b.din) begin
          next_s.drv.dal[`PEC_CSR_W-1:0]    = '0;
          next_s.drv.dal_oe[`PEC_CSR_W-1:0] = '0;
          next_s.drv.rply = 1'b0;
          flag_clr  = 1'b1;
          next_s.st = PEC_CYC;
        end
      end
      PEC_WR: begin
        next_s.drv.rply = 1'b1;
        if (!b.dout) begin
          next_s.drv.rply = 1'b0;
          next_s.st       = PEC_WAIT;
        end
      end
      PEC_WAIT: begin
        if (!b.sync) begin
          next_s.sel = 1'b0;
          next_s.st  = PEC_IDLE;
        end
      end
      default: begin
        next_s.sel = 1'b0;
        next_s.st  = PEC_IDLE;
      end
    endcase

    // Register write of control bits
    if (wr_low) begin
      next_s.en  = b.dal[`PEC_CSR_EN];
      next_s.wwp = b.dal[`PEC_CSR_WWP];
    end

    // Set wins over read clear
    next_s.flag = (s.flag & ~flag_clr) | flag_set;

    // ****************************************
    // Bus initialize
    // ****************************************
    if (b.init) begin
      next_s.en   = 1'b0;
      next_s.wwp  = 1'b0;
      next_s.flag = 1'b0;
      next_s.sel  = 1'b0;
      next_s.drv  = '0;
      next_s.st   = PEC_IDLE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s         <= '0;
      s.st      <= PEC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dal_o    = s.drv.dal;
  assign dal_oe_o = s.drv.dal_oe;
  assign rply_o   = s.drv.rply;

endmodule : pec_top
`default_nettype wire

//--- sim/pec_checker.sv
`default_nettype none
module pec_checker
  import pec_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire pec_bus_t    bus_i,
  input  wire logic [3:0]  jumper_i,
  input  wire logic [17:0] dal_o,
  input  wire logic [17:0] dal_oe_o,
  input  wire logic        rply_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_din_gone; !bus_i.din [*5]; endsequence
  sequence s_dout_gone; !bus_i.dout [*5]; endsequence
  sequence s_csr_data; rply_o && dal_oe_o[15]; endsequence
  a_unused_zero: assert property (s_csr_data |-> dal_o[14:12] == 3'h0 && dal_o[4:3] == 2'h0
    && !dal_o[1]) else $error("unused bit read high");
  a_drive_whole: assert property (s_csr_data |-> dal_oe_o[15:0] == 16'hFFFF)
    else $error("partial data drive");
  a_drive_release: assert property (s_din_gone |-> !dal_oe_o[15])
    else $error("data lines held");
  a_line17_din: assert property (s_din_gone |-> !dal_oe_o[17])
    else $error("line 17 outside read");
  a_line17_en: assert property (s_csr_data ##0 dal_oe_o[17] |-> dal_o[17] && dal_o[0])
    else $error("line 17 without enable");
  a_line16_dout: assert property (s_dout_gone |-> !dal_oe_o[16])
    else $error("line 16 outside write");
  a_rply_sync: assert property (!bus_i.sync [*6] |-> !rply_o)
    else $error("reply outside cycle");
  a_init_quiet: assert property (bus_i.init [*6] |-> dal_oe_o[17:16] == 2'h0)
    else $error("control lines after init");
endmodule : pec_checker
`default_nettype wire

//--- sim/pec_mem_model.sv
`default_nettype none
module pec_mem_model
  import pec_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire pec_bus_t    bus_i,
  output logic             rply_o,
  output logic [17:0]      dal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  bit   [127:0] bad;
  logic [17:0]  adr = 18'h3FFFF;
  logic         sync_q = 1'b0;
  int           cnt;
  int           thr;
  initial rply_o = 1'b0;
  initial dal_o = 18'h0;
  // ****************************************
  // Memory answering below address bit 17
  // ****************************************
  always @(posedge mclk_i) begin
    sync_q <= bus_i.sync;
    if (bus_i.sync && !sync_q) begin
      adr <= bus_i.dal;
    end
    thr = 6 + int'(adr[2:0]);
    cnt = (bus_i.sync && (bus_i.din || bus_i.dout) && !adr[17]) ? cnt + 1 : 0;
    if (bus_i.dout && cnt == thr) begin
      bad[adr[17:11]] <= bus_i.dal[16];
    end
    rply_o <= cnt >= thr;
    dal_o <= {1'b0, bus_i.din && cnt >= thr && bad[adr[17:11]], 16'h0};
  end
endmodule : pec_mem_model
`default_nettype wire

//--- sim/parity_error_controller_tb.sv
`default_nettype none
module parity_error_controller_tb
  import pec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        sync, din, dout, init, rply_o, mrply;
  logic        rq = 1'b0;
  logic        wtbt = 1'b0;
  logic [3:0]  jmp;
  logic [15:0] d;
  logic [17:0] dal_o, dal_oe_o, tdal, mdal, a, parity_control_status;
  logic [17:0] exq[$];
  logic [31:0] seed = 32'h00018101;
  pec_bus_t    bus;
  int          err_count, checks, cyc_n;
  always #2.5 mclk_i = ~mclk_i;
  assign bus = {sync, din, dout, mrply | rply_o, wtbt, init, tdal | mdal | (dal_o & dal_oe_o)};
  pec_top i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_i(bus), .jumper_i(jmp),
    .dal_o(dal_o), .dal_oe_o(dal_oe_o), .rply_o(rply_o));
  pec_mem_model i_mem (.mclk_i(mclk_i), .bus_i(bus), .rply_o(mrply), .dal_o(mdal));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [17:0] cexp(logic en, logic wwp, logic flg, logic [6:0] ea);
    return {en, 1'b0, flg, 3'h0, ea, 2'h0, wwp, 1'b0, en};
  endfunction : cexp
  // ****************************************
  // Processor side bus cycle
  // ****************************************
  task automatic cyc(input logic [17:0] ad, input logic wr, input logic [17:0] e);
    int n;
    exq.push_back(e);
    @(posedge mclk_i);
    #1;
    sync = 1'b1;
    tdal = ad;
    repeat (3) @(posedge mclk_i);
    #1;
    tdal = wr ? {2'h0, d} : 18'h0;
    din = !wr;
    dout = wr;
    for (n = 0; n < 40 && !bus.rply; n++) begin
      @(posedge mclk_i);
      #1;
    end
    if (bus.rply !== 1'b1) begin
      err_count++;
      $display("BAD rply expected 1 seen %b", bus.rply);
    end
    repeat (40) @(posedge mclk_i);
    #1;
    din = 1'b0;
    dout = 1'b0;
    tdal = 18'h0;
    for (n = 0; n < 40 && bus.rply; n++) begin
      @(posedge mclk_i);
      #1;
    end
    sync = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask : cyc
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk_i) begin
    rq <= bus.rply;
    cyc_n++;
    if (bus.rply && !rq && exq.size() > 0) begin
      checks++;
      if (bus.dal !== exq[0]) begin
        err_count++;
        $display("BAD dal expected %h seen %h", exq[0], bus.dal);
      end
      void'(exq.pop_front());
    end
    if (cyc_n == 5000) begin
      err_count++;
      $display("BAD cyc_n expected below %0d seen %0d", 5000, cyc_n);
      tally_and_finish();
    end
  end
  initial begin
    {sync, din, dout, init, tdal} = 22'h0;
    jmp = 4'(rnd());
    parity_control_status = {13'h1FA2, jmp, seed[0]};
    a = {1'b0, 17'(rnd())};
    d = 16'(rnd()) | 16'h0005;
    repeat (4) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    cyc(parity_control_status, 1'b0, cexp(1'b0, 1'b0, 1'b0, 7'h7E));
    cyc(parity_control_status, 1'b1, {2'h0, d});
    cyc(parity_control_status, 1'b0, cexp(1'b1, 1'b1, 1'b0, 7'h7E));
    wtbt = 1'b1;
    cyc(a, 1'b1, {2'h1, d});
    d = d ^ 16'h0005;
    cyc({parity_control_status[17:1], 1'b1}, 1'b1, {2'h0, d});
    wtbt = 1'b0;
    cyc(a, 1'b0, {2'h3, 16'h0});
    cyc(a ^ 18'h00800, 1'b0, {2'h2, 16'h0});
    cyc(parity_control_status, 1'b0, cexp(1'b1, 1'b1, 1'b1, a[17:11]));
    cyc(parity_control_status, 1'b0, cexp(1'b1, 1'b1, 1'b0, 7'h7E));
    cyc(a, 1'b0, {2'h3, 16'h0});
    init = 1'b1;
    repeat (8) @(posedge mclk_i);
    #1;
    init = 1'b0;
    repeat (4) @(posedge mclk_i);
    cyc(parity_control_status, 1'b0, cexp(1'b0, 1'b0, 1'b0, 7'h7E));
    cyc(a, 1'b0, {2'h1, 16'h0});
    if (exq.size() != 0) begin
      err_count++;
      $display("BAD exq expected 0 seen %0d", exq.size());
    end
    tally_and_finish();
  end
endmodule : parity_error_controller_tb
bind pec_top pec_checker i_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
  .jumper_i(jumper_i), .dal_o(dal_o), .dal_oe_o(dal_oe_o), .rply_o(rply_o));
`default_nettype wire
